// >>> core/dsr_pkg.sv
`default_nettype none
package dsr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DSR_STATUS_OFS = 8'h14; // Status word
  localparam logic [7:0] DSR_MASK_OFS   = 8'h1C; // Interrupt enables
  localparam logic [7:0] DSR_CTRL_OFS   = 8'h18; // Start/stop control
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DSR_TX_LSB  = 20; // Transmit state field
  localparam int DSR_RX_LSB  = 17; // Receive state field
  localparam int DSR_NIS_BIT = 16; // Normal summary
  localparam int DSR_TI_BIT  = 0;  // Transmit done
  localparam int DSR_TU_BIT  = 2;  // Transmit descriptor unavailable
  localparam int DSR_RI_BIT  = 6;  // Receive done
  localparam int DSR_CTL_TX  = 0;  // Control: transmit start
  localparam int DSR_CTL_RX  = 1;  // Control: receive start
  localparam logic [31:0] DSR_ZERO = 32'h0000_0000; // Reset value
  // ----------------------------------------------------------------
  // Process state codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TX_STOP  = 3'h0;
  localparam logic [2:0] TX_FETCH = 3'h1;
  localparam logic [2:0] TX_WAIT  = 3'h2;
  localparam logic [2:0] TX_READ  = 3'h3;
  localparam logic [2:0] TX_SUSP  = 3'h6;
  localparam logic [2:0] TX_CLOSE = 3'h7;
  localparam logic [2:0] RX_STOP  = 3'h0;
  localparam logic [2:0] RX_FETCH = 3'h1;
  localparam logic [2:0] RX_CHECK = 3'h2;
  localparam logic [2:0] RX_WAITP = 3'h3;
  localparam logic [2:0] RX_SUSP  = 3'h4;
  localparam logic [2:0] RX_CLOSE = 3'h5;
  localparam logic [2:0] RX_FLUSH = 3'h6;
  localparam logic [2:0] RX_QUEUE = 3'h7;
  // Engine events; encodings are internal
  typedef enum {DSR_IDLE, DSR_TXRUN, DSR_RXRUN} dsr_dummy_e;
endpackage
`default_nettype wire

// >>> core/dsr_skid_buffer.sv
`default_nettype none
// Two-entry buffer for status words headed to the host side
module dsr_skid_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [2];      // Two slots
  logic [WIDTH-1:0] mem_next [2];
  logic             wp_reg, wp_next;  // Write slot
  logic             rp_reg, rp_next;  // Read slot
  logic [1:0]       cnt_reg, cnt_next; // Occupancy
  logic [WIDTH-1:0] head_reg, head_next;   // Registered copy of the read slot
  logic             valid_reg, valid_next; // Registered not-empty flag

  // outData and outValid come from flops so the far side never sees a slot mux settle
  assign inReady  = (cnt_reg != 2'h2);
  assign outValid = valid_reg;
  assign outData  = head_reg;

  // Next-state for pointers and slots
  always_comb
  begin
    logic push;
    logic pop;
    push = inValid && inReady;
    pop  = outValid && outReady;
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      mem_next[wp_reg] = inData;
      wp_next = ~wp_reg;
    end
    if (pop)
      rp_next = ~rp_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 2'h1;
    else if (pop && !push)
      cnt_next = cnt_reg - 2'h1;
    // Word that the read slot will hold after this edge
    head_next  = mem_next[rp_next];
    valid_next = (cnt_next != 2'h0);
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      head_reg   <= '0;
      valid_reg  <= 1'b0;
    end
    else
    begin
      mem_reg   <= mem_next;
      wp_reg    <= wp_next;
      rp_reg    <= rp_next;
      cnt_reg   <= cnt_next;
      head_reg  <= head_next;
      valid_reg <= valid_next;
    end
  end
endmodule // dsr_skid_buffer
`default_nettype wire

// >>> core/dsr_status.sv
// Chosen here: strobed register access.
`default_nettype none
// Status reporting of the descriptor DMA: encoded process states,
// sticky event flags, and the normal interrupt summary.
// The engines themselves live elsewhere; this block only follows
// their event pulses and shows the result to software.
// Every event input is a one-cycle pulse and is heeded only in the
// state that expects it, so a stray pulse cannot skip a state.
// Limitation: one event per engine is taken in a cycle; the engines
// never raise two at once.
// The status word is also streamed to a host-side mirror through a
// two-entry buffer, so a stalled mirror never blocks the engines.
// Trade-off: the mirror may miss an intermediate word under stall,
// but the last word it receives carries the live states and flags; a summary-only change is not posted.
// Clearing a start bit stops its process on the next edge, whatever
// the engine is doing; software must let a frame finish first.
module dsr_status (
  input  wire logic        ref_clk,     // 10 MHz system clock
  input  wire logic        rst_n,       // Synchronous, active low
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  // Transmit engine events
  input  wire logic        txDescFetched, // Descriptor owned by DMA
  input  wire logic        txDescHost,    // Descriptor owned by host
  input  wire logic        txDataDone,    // Buffer copied to FIFO
  input  wire logic        txFrameDone,   // End of transmission
  input  wire logic        txClosed,      // Descriptor written back
  input  wire logic        txPollDemand,  // Poll write from host
  // Receive engine events
  input  wire logic        rxDescFetched,
  input  wire logic        rxDescHost,
  input  wire logic        rxFrameStart,  // Packet arriving
  input  wire logic        rxNoBuffer,    // Buffer lacking
  input  wire logic        rxFrameEnd,    // Frame in host memory
  input  wire logic        rxFlushDone,
  input  wire logic        rxClosed,
  input  wire logic        rxPollDemand,
  // Status word stream to the host-side mirror
  output logic [31:0]      statData,
  output logic             statValid,
  input  wire logic        statReady,
  // Engine control and interrupt
  output logic             txRunOut,
  output logic             rxRunOut,
  output logic             hostIrq
);
  // ----------------------------------------------------------------
  // Process state machines
  // ----------------------------------------------------------------
  // Enum codes are internal; the status word carries the encoded form
  typedef enum {TS_STOP, TS_FETCH, TS_READ, TS_WAIT, TS_CLOSE, TS_SUSP} dsr_tx_e;
  typedef enum {RS_STOP, RS_FETCH, RS_WAITP, RS_QUEUE, RS_FLUSH, RS_CHECK,
                RS_CLOSE, RS_SUSP} dsr_rx_e;

  dsr_tx_e     txSt_reg, txSt_next;     // Transmit process
  dsr_rx_e     rxSt_reg, rxSt_next;     // Receive process
  logic [1:0]  ctrl_reg, ctrl_next;     // Start bits
  logic [2:0]  mask_reg, mask_next;     // Enables for TI, TU, RI
  logic [2:0]  flags_reg, flags_next;   // Sticky TI, TU, RI
  logic        nis_reg, nis_next;       // Summary
  logic [31:0] rdata_reg, rdata_next;   // Read data
  logic        irq_reg, irq_next;
  logic        pushPend_reg, pushPend_next; // Status changed, not yet queued
  logic [31:0] statWord;
  logic        bufReady;

  // Write strobe aimed at one register; shared by every write decode
  // Strobe and address come in as arguments so the function stays pure
  function automatic logic dsr_wr_hit(input logic       wr,
                                      input logic [7:0] addr,
                                      input logic [7:0] ofs);
    dsr_wr_hit = wr && (addr == ofs);
  endfunction

  // Encode transmit state; reserved 100/101 unreachable
  function automatic logic [2:0] dsr_tx_code(input dsr_tx_e s);
    case (s)
      TS_FETCH: dsr_tx_code = dsr_pkg::TX_FETCH;
      TS_WAIT:  dsr_tx_code = dsr_pkg::TX_WAIT;
      TS_READ:  dsr_tx_code = dsr_pkg::TX_READ;
      TS_CLOSE: dsr_tx_code = dsr_pkg::TX_CLOSE;
      TS_SUSP:  dsr_tx_code = dsr_pkg::TX_SUSP;
      default:  dsr_tx_code = dsr_pkg::TX_STOP;
    endcase
  endfunction

  // Encode receive state
  // Every receive code is in use; none is reserved
  function automatic logic [2:0] dsr_rx_code(input dsr_rx_e s);
    case (s)
      RS_FETCH: dsr_rx_code = dsr_pkg::RX_FETCH;
      RS_CHECK: dsr_rx_code = dsr_pkg::RX_CHECK;
      RS_WAITP: dsr_rx_code = dsr_pkg::RX_WAITP;
      RS_SUSP:  dsr_rx_code = dsr_pkg::RX_SUSP;
      RS_QUEUE: dsr_rx_code = dsr_pkg::RX_QUEUE;
      RS_CLOSE: dsr_rx_code = dsr_pkg::RX_CLOSE;
      RS_FLUSH: dsr_rx_code = dsr_pkg::RX_FLUSH;
      default:  dsr_rx_code = dsr_pkg::RX_STOP;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Assemble the status word; upper bits stay zero
  // Summary and flags sit at fixed positions below the two fields
  always_comb
  begin
    statWord = dsr_pkg::DSR_ZERO;
    statWord[dsr_pkg::DSR_TX_LSB +: 3] = dsr_tx_code(txSt_reg);
    statWord[dsr_pkg::DSR_RX_LSB +: 3] = dsr_rx_code(rxSt_reg);
    statWord[dsr_pkg::DSR_NIS_BIT]     = nis_reg;
    statWord[dsr_pkg::DSR_TI_BIT]      = flags_reg[0];
    statWord[dsr_pkg::DSR_TU_BIT]      = flags_reg[1];
    statWord[dsr_pkg::DSR_RI_BIT]      = flags_reg[2];
  end

  // ----------------------------------------------------------------
  // Transmit process
  // ----------------------------------------------------------------
  // Next transmit state; a cleared start bit wins over any event
  // Suspension is left only by a poll, never by a new descriptor alone
  always_comb
  begin
    txSt_next = txSt_reg;
    if (!ctrl_reg[dsr_pkg::DSR_CTL_TX])
      txSt_next = TS_STOP;
    else
      case (txSt_reg)
        TS_STOP:  txSt_next = TS_FETCH;
        TS_FETCH:
          if (txDescHost)
            txSt_next = TS_SUSP;
          else if (txDescFetched)
            txSt_next = TS_READ;
        TS_READ:  if (txDataDone)  txSt_next = TS_WAIT;
        TS_WAIT:  if (txFrameDone) txSt_next = TS_CLOSE;
        TS_CLOSE: if (txClosed)    txSt_next = TS_FETCH;
        TS_SUSP:  if (txPollDemand) txSt_next = TS_FETCH;
        default:  txSt_next = TS_STOP;
      endcase
  end

  // ----------------------------------------------------------------
  // Receive process
  // ----------------------------------------------------------------
  // Next receive state; a cleared start bit wins over any event
  // A lacking buffer flushes the frame, then waits for the next one
  always_comb
  begin
    rxSt_next = rxSt_reg;
    if (!ctrl_reg[dsr_pkg::DSR_CTL_RX])
      rxSt_next = RS_STOP;
    else
      case (rxSt_reg)
        RS_STOP:  rxSt_next = RS_FETCH;
        RS_FETCH:
          if (rxDescHost)
            rxSt_next = RS_SUSP;
          else if (rxDescFetched)
            rxSt_next = RS_WAITP;
        RS_WAITP: if (rxFrameStart) rxSt_next = RS_QUEUE;
        RS_QUEUE:
          if (rxNoBuffer)
            rxSt_next = RS_FLUSH;
          else if (rxFrameEnd)
            rxSt_next = RS_CLOSE;
        RS_FLUSH: if (rxFlushDone) rxSt_next = RS_WAITP;
        RS_CLOSE: if (rxClosed)    rxSt_next = RS_CHECK;
        RS_CHECK: rxSt_next = RS_FETCH;
        // Suspended wakes on poll or a new incoming frame
        RS_SUSP:  if (rxPollDemand || rxFrameStart) rxSt_next = RS_FETCH;
        default:  rxSt_next = RS_STOP;
      endcase
  end

  // ----------------------------------------------------------------
  // Flags, summary and register port
  // ----------------------------------------------------------------
  // Next values of flags, summary, mask, control and read data
  always_comb
  begin
    logic [2:0] setEv;
    logic [2:0] clrEv;
    logic       stWr;
    stWr  = dsr_wr_hit(regWr, regAddr, dsr_pkg::DSR_STATUS_OFS);
    // TI and TU are set on the transmit close and suspend steps, RI on receive close
    setEv[0] = (txSt_reg == TS_CLOSE) && txClosed;
    setEv[1] = (txSt_reg == TS_FETCH) && txDescHost;
    setEv[2] = (rxSt_reg == RS_CLOSE) && rxClosed;
    // Write one to clear; a zero bit leaves its flag alone
    clrEv = stWr ? {regWdata[dsr_pkg::DSR_RI_BIT], regWdata[dsr_pkg::DSR_TU_BIT],
                    regWdata[dsr_pkg::DSR_TI_BIT]} : 3'h0;
    // Set beats a same-cycle write-one clear
    flags_next = (flags_reg & ~clrEv) | setEv;
    nis_next   = |(flags_next & mask_reg);
    if (stWr && regWdata[dsr_pkg::DSR_NIS_BIT] && !(|(setEv & mask_reg)))
      nis_next = 1'b0;
    irq_next   = nis_next;
    // Mask and control take the whole written field
    mask_next  = mask_reg;
    ctrl_next  = ctrl_reg;
    if (dsr_wr_hit(regWr, regAddr, dsr_pkg::DSR_MASK_OFS))
      mask_next = {regWdata[dsr_pkg::DSR_RI_BIT], regWdata[dsr_pkg::DSR_TU_BIT],
                   regWdata[dsr_pkg::DSR_TI_BIT]};
    if (dsr_wr_hit(regWr, regAddr, dsr_pkg::DSR_CTRL_OFS))
      ctrl_next = regWdata[1:0];
    rdata_next = dsr_pkg::DSR_ZERO;                                // Unmapped reads 0
    // Read data is zero outside the cycle after a read strobe
    if (regRd)
      case (regAddr)
        dsr_pkg::DSR_STATUS_OFS: rdata_next = statWord;
        dsr_pkg::DSR_MASK_OFS:   rdata_next = {25'h0, mask_reg[2], 3'h0,
                                               mask_reg[1], 1'b0, mask_reg[0]};
        dsr_pkg::DSR_CTRL_OFS:   rdata_next = {30'h0, ctrl_reg};
        default:                 rdata_next = dsr_pkg::DSR_ZERO;
      endcase
    // Post a snapshot whenever a state or flag changes; stall keeps it pending
    // A change met by a full buffer is retried with the live word
    pushPend_next = (pushPend_reg && !bufReady) ||
                    (txSt_next != txSt_reg) || (rxSt_next != rxSt_reg) ||
                    (flags_next != flags_reg);
  end

  // ----------------------------------------------------------------
  // Status stream
  // ----------------------------------------------------------------
  // Status snapshot buffer; snapshot may lag by several changes when stalled
  // Its stream outputs are registered inside, so the stream leaves from flops
  dsr_skid_buffer #(.WIDTH(32)) uBuf (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inData   (statWord),
    .inValid  (pushPend_reg),
    .inReady  (bufReady),
    .outData  (statData),
    .outValid (statValid),
    .outReady (statReady)
  );

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Transmit process state; reads the stop code after reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      txSt_reg <= TS_STOP;
    end
    else
    begin
      txSt_reg <= txSt_next;
    end
  end

  // Receive process state; reads the stop code after reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rxSt_reg <= RS_STOP;
    end
    else
    begin
      rxSt_reg <= rxSt_next;
    end
  end

  // Flags, summary, register port and run outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg     <= 2'h0;
      mask_reg     <= 3'h0;
      flags_reg    <= 3'h0;
      nis_reg      <= 1'b0;
      rdata_reg    <= dsr_pkg::DSR_ZERO;
      irq_reg      <= 1'b0;
      pushPend_reg <= 1'b0;
      txRunOut     <= 1'b0;
      rxRunOut     <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      mask_reg     <= mask_next;
      flags_reg    <= flags_next;
      nis_reg      <= nis_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
      pushPend_reg <= pushPend_next;
      txRunOut     <= ctrl_next[dsr_pkg::DSR_CTL_TX];
      rxRunOut     <= ctrl_next[dsr_pkg::DSR_CTL_RX];
    end
  end

  // Outputs straight from their registers
  assign regRdata = rdata_reg;
  assign hostIrq  = irq_reg;
endmodule // dsr_status
`default_nettype wire

// >>> verification/dsr_status_checker.sv
`default_nettype none
// Port-level checks of the status reporting block
module dsr_status_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [31:0] statData,
  input wire logic        statValid,
  input wire logic        statReady,
  input wire logic        txRunOut,
  input wire logic        rxRunOut,
  input wire logic        hostIrq
);
  // ----------------------------------------------------------------
  // Common clock and reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Status read request
  sequence s_stat_rd;
    regRd && regAddr == dsr_pkg::DSR_STATUS_OFS;
  endsequence
  // Control write, one quiet cycle, then a status read
  sequence s_stop(int b);
    regWr && regAddr == dsr_pkg::DSR_CTRL_OFS && !regWdata[b] ##1 !regWr ##1 s_stat_rd;
  endsequence
  // Mask cleared and left alone for three cycles
  sequence s_masked;
    regWr && regAddr == dsr_pkg::DSR_MASK_OFS && regWdata[6:0] == 7'h00
      ##1 !(regWr && regAddr == dsr_pkg::DSR_MASK_OFS) [*3];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rsvd_bits_zero: assert property (regRdata[31:23] == 9'h000)
    else $error("reserved status bits read nonzero");
  chk_tx_code_legal: assert property (regRdata[22:20] != 3'h4 && regRdata[22:20] != 3'h5)
    else $error("reserved transmit code reported");
  // Read data only stands in the cycle after a read
  chk_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property ($past(regRd) && $past(regAddr) != dsr_pkg::DSR_STATUS_OFS
      && $past(regAddr) != dsr_pkg::DSR_CTRL_OFS && $past(regAddr) != dsr_pkg::DSR_MASK_OFS
      |-> regRdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_tx_stop_code: assert property (s_stop(dsr_pkg::DSR_CTL_TX) |=> regRdata[22:20] == 3'h0)
    else $error("transmit not stopped after stop");
  chk_rx_stop_code: assert property (s_stop(dsr_pkg::DSR_CTL_RX) |=> regRdata[19:17] == 3'h0)
    else $error("receive not stopped after stop");
  chk_run_copy: assert property (regWr && regAddr == dsr_pkg::DSR_CTRL_OFS
      |=> txRunOut == $past(regWdata[0]) && rxRunOut == $past(regWdata[1]))
    else $error("run outputs do not follow control");
  chk_masked_no_irq: assert property (s_masked |-> !hostIrq)
    else $error("interrupt with all sources masked");
  // A stalled word must wait unchanged
  chk_stream_hold: assert property (statValid && !statReady |=> statValid && $stable(statData))
    else $error("stalled status word lost");
endmodule // dsr_status_checker
bind dsr_status dsr_status_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .statData(statData),
  .statValid(statValid), .statReady(statReady), .txRunOut(txRunOut), .rxRunOut(rxRunOut),
  .hostIrq(hostIrq));
`default_nettype wire

// >>> verification/dsr_status_tb_top.sv
`default_nettype none
// Self-checking bench for the status reporting block
module dsr_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk;   // 10 MHz clock
  logic        rst_n;     // Active-low reset
  logic [7:0]  regAddr;   // Register address
  logic [31:0] regWdata;  // Write data
  logic        regWr;     // Write strobe
  logic        regRd;     // Read strobe
  logic [31:0] regRdata;  // Read data
  logic [13:0] ev;        // One-hot engine event pulses
  logic [31:0] statData;  // Stream word
  logic        statValid; // Stream valid
  logic        statReady; // Stream ready, held low to stall
  logic        txRunOut;  // Transmit run
  logic        rxRunOut;  // Receive run
  logic        hostIrq;   // Interrupt
  logic [31:0] st;        // Last status read
  int          nErrors;   // Mismatches
  int          checked;   // Comparisons
  dsr_status u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txDescFetched(ev[0]),
    .txDescHost(ev[1]), .txDataDone(ev[2]), .txFrameDone(ev[3]), .txClosed(ev[4]),
    .txPollDemand(ev[5]), .rxDescFetched(ev[6]), .rxDescHost(ev[7]), .rxFrameStart(ev[8]),
    .rxNoBuffer(ev[9]), .rxFrameEnd(ev[10]), .rxFlushDone(ev[11]), .rxClosed(ev[12]),
    .rxPollDemand(ev[13]), .statData(statData), .statValid(statValid),
    .statReady(statReady), .txRunOut(txRunOut), .rxRunOut(rxRunOut), .hostIrq(hostIrq));
  // Clock
  always #50 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d, comparisons %0d", nErrors, checked);
    if (nErrors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Write cycle; the next task drops the strobe, so writes may chain
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
  endtask
  // Optional event pulse, then a status read right behind it
  task automatic step(input logic [13:0] e);
    @(posedge ref_clk);
    regWr <= 1'b0;
    ev <= e;
    @(posedge ref_clk);
    ev <= 14'h0000;
    regRd <= 1'b1;
    regAddr <= dsr_pkg::DSR_STATUS_OFS;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 st = regRdata;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    step(14'h0000);
    check(st, 32'h0000_0000, "status after reset");
    wr(8'h20, 32'hFFFF_FFFF);
    step(14'h0000);
    check(st, 32'h0000_0000, "status after unmapped write");
  endtask
  // Walk the transmit codes; flags must stay out of the summary until done
  task automatic test_tx;
    int         idx[6] = '{0, 2, 3, 4, 1, 5};
    logic [2:0] code[6] = '{3'h3, 3'h2, 3'h7, 3'h1, 3'h6, 3'h1};
    wr(dsr_pkg::DSR_MASK_OFS, 32'h0000_0045);
    wr(dsr_pkg::DSR_CTRL_OFS, 32'h0000_0001);
    step(14'h0000);
    check(32'(st[22:20]), 32'h0000_0001, "tx fetch");
    for (int k = 0; k < 6; k++)
    begin
      step(14'h0001 << idx[k]);
      check(32'(st[22:20]), 32'(code[k]), "tx code");
      if (k < 3)
        check(32'(hostIrq), 32'h0000_0000, "irq on state change");
    end
    step(14'h0000);
    check(st & 32'h0001_0005, 32'h0001_0005, "tx flags and summary");
    check(32'(hostIrq), 32'h0000_0001, "irq raised");
    wr(dsr_pkg::DSR_STATUS_OFS, 32'h0001_0005);
    step(14'h0000);
    check(st & 32'h0001_0005, 32'h0000_0000, "flags cleared");
    step(14'h0000);
    check(32'(hostIrq), 32'h0000_0000, "irq cleared");
    wr(dsr_pkg::DSR_CTRL_OFS, 32'h0000_0000);
    step(14'h0000);
    check(32'(st[22:20]), 32'h0000_0000, "tx stopped");
  endtask
  // Walk the receive codes with every source masked
  task automatic test_rx;
    int         idx[9] = '{7, 13, 6, 8, 9, 11, 8, 10, 12};
    logic [2:0] code[9] = '{3'h4, 3'h1, 3'h3, 3'h7, 3'h6, 3'h3, 3'h7, 3'h5, 3'h2};
    wr(dsr_pkg::DSR_MASK_OFS, 32'h0000_0000);
    wr(dsr_pkg::DSR_CTRL_OFS, 32'h0000_0002);
    step(14'h0000);
    check(32'(st[19:17]), 32'h0000_0001, "rx fetch");
    for (int k = 0; k < 9; k++)
    begin
      step(14'h0001 << idx[k]);
      check(32'(st[19:17]), 32'(code[k]), "rx code");
    end
    step(14'h0000);
    check(32'(st[19:17]), 32'h0000_0001, "rx refetch");
    check(st & 32'h0001_0040, 32'h0000_0040, "masked flag recorded");
    check(32'(hostIrq), 32'h0000_0000, "masked irq");
    wr(dsr_pkg::DSR_CTRL_OFS, 32'h0000_0000);
    step(14'h0000);
    check(32'(st[19:17]), 32'h0000_0000, "rx stopped");
  endtask
  // Release the stalled stream and drain it; the last word is the live status
  task automatic test_stream;
    logic [31:0] last;
    int          n;
    last = 32'h0000_0000;
    n = 0;
    check(32'(statValid), 32'h0000_0001, "stream held");
    @(posedge ref_clk);
    statReady <= 1'b1;
    while (n < 20)
    begin
      @(negedge ref_clk);
      if (statValid !== 1'b1)
        break;
      last = statData;
      n++;
    end
    if (n == 20)
    begin
      nErrors++;
      $display("unexpected at %0t: stream never drained", $time);
      give_verdict();
    end
    step(14'h0000);
    check(st, 32'h0000_0040, "idle status, receive flag kept");
    check(last, 32'h0000_0040, "last streamed word");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    ev = 14'h0000;
    statReady = 1'b0;
    nErrors = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_tx();
    test_rx();
    test_stream();
    give_verdict();
  end
endmodule // dsr_status_tb_top
`default_nettype wire
